// file: src/fsp_cfg.svh
// Constants of the framer system-side serial port
`ifndef FSP_CFG_SVH
`define FSP_CFG_SVH

// Marker lead in reference clocks
`define FSP_MARKER_LEAD 3
`define FSP_POS_W 13

// DS3 framed layout: 56 blocks of 85 bits, one overhead bit heads each block
`define FSP_DS3_BLOCK_BITS 13'h0055
`define FSP_DS3_OH_BITS 13'h0001
`define FSP_DS3_FRAME_BITS 13'h1298

// E3 framed layout: 1536-bit frame, 12 overhead bits at its head
`define FSP_E3_BLOCK_BITS 13'h0600
`define FSP_E3_OH_BITS 13'h000C
`define FSP_E3_FRAME_BITS 13'h0600

// Synchroniser lanes
`define FSP_SYN_W 6
`define FSP_SYN_TXREF 0
`define FSP_SYN_TXLCLK 1
`define FSP_SYN_RXLCLK 2
`define FSP_SYN_TXSER 3
`define FSP_SYN_RXDAT 4
`define FSP_SYN_RXLIU 5

// Polarity inversion vector bit positions
`define FSP_INV_W 9
`define FSP_INV_TXREF 0
`define FSP_INV_TXLCLK 1
`define FSP_INV_RXLCLK 2
`define FSP_INV_TXSER 3
`define FSP_INV_TXMRK 4
`define FSP_INV_TXCLKO 5
`define FSP_INV_RXSER 6
`define FSP_INV_RXCLKO 7
`define FSP_INV_RXMRK 8

`endif

// file: src/fsp_pkg.sv
// Types of the framer system-side serial port
package fsp_pkg;

    typedef enum logic [1:0] {
        MODE_UNFRAMED = 2'h0,
        MODE_DS3 = 2'h1,
        MODE_E3 = 2'h3
    } framer_mode_e;

    typedef enum logic [2:0] {
        TXREF_TX_CLOCK_IN = 3'h0,
        TXREF_TX_LINE_CLOCK = 3'h1,
        TXREF_TX_CLOCK_OUT = 3'h3,
        TXREF_RX_CLOCK_OUT = 3'h2,
        TXREF_RX_LINE_CLOCK = 3'h6
    } tx_ref_sel_e;

    typedef enum logic [1:0] {
        RXREF_RX_CLOCK_OUT = 2'h0,
        RXREF_RX_GAPPED = 2'h1,
        RXREF_RX_LINE_CLOCK = 2'h3
    } rx_ref_sel_e;

endpackage : fsp_pkg

// file: src/fsp_fifo_if.sv
// Valid/ready carrier between the port and its payload FIFO
`timescale 1ns/1ns
interface fsp_fifo_if #(
    parameter int WIDTH = 8
);
    logic wr_valid;
    logic wr_ready;
    logic [WIDTH-1:0] wr_data;
    logic rd_valid;
    logic rd_ready;
    logic [WIDTH-1:0] rd_data;

    modport store (
        input wr_valid, wr_data, rd_ready,
        output wr_ready, rd_valid, rd_data
    );
    modport user (
        output wr_valid, wr_data, rd_ready,
        input wr_ready, rd_valid, rd_data
    );
endinterface : fsp_fifo_if

// file: src/fsp_fifo.sv
// Flip-flop FIFO with valid/ready on both sides
`timescale 1ns/1ns
module fsp_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 32
) (
    input wire logic clk_sys_i,
    input wire logic rst_i,
    fsp_fifo_if.store bus
);
    localparam int AW = $clog2(DEPTH);

    logic [WIDTH-1:0] mem_r [DEPTH];
    logic [AW-1:0] wr_ptr_r;
    logic [AW-1:0] rd_ptr_r;
    logic [AW:0] count_r;
    logic push;
    logic pop;

    assign bus.wr_ready = (count_r != (AW+1)'(DEPTH));
    assign bus.rd_valid = (count_r != '0);
    assign bus.rd_data = mem_r[rd_ptr_r];
    assign push = bus.wr_valid && bus.wr_ready;
    assign pop = bus.rd_valid && bus.rd_ready;

    always_ff @(posedge clk_sys_i)
    begin
        if (push)
        begin
            mem_r[wr_ptr_r] <= bus.wr_data;
        end
    end

    always_ff @(posedge clk_sys_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            wr_ptr_r <= '0;
            rd_ptr_r <= '0;
            count_r <= '0;
        end
        else
        begin
            if (push)
            begin
                wr_ptr_r <= (wr_ptr_r == AW'(DEPTH - 1)) ? '0 : wr_ptr_r + 1'b1;
            end
            if (pop)
            begin
                rd_ptr_r <= (rd_ptr_r == AW'(DEPTH - 1)) ? '0 : rd_ptr_r + 1'b1;
            end
            if (push && !pop)
            begin
                count_r <= count_r + 1'b1;
            end
            else if (pop && !push)
            begin
                count_r <= count_r - 1'b1;
            end
        end
    end
endmodule : fsp_fifo

// file: src/framer_sys_port.sv
// System-side serial port of one framer port, framed modes
`timescale 1ns/1ns
`include "fsp_cfg.svh"
module framer_sys_port
    import fsp_pkg::*;
#(
    parameter int FIFO_WIDTH = 8,
    parameter int FIFO_DEPTH = 32
) (
    input wire logic clk_sys_i,
    input wire logic rst_i,
    input wire framer_mode_e framer_mode_i,
    input wire logic tx_marker_sel_i,
    input wire logic tx_clk_sel_i,
    input wire tx_ref_sel_e tx_ref_sel_i,
    input wire rx_ref_sel_e rx_ref_sel_i,
    input wire logic rx_clk_sel_i,
    input wire logic rx_marker_sel_i,
    input wire logic rx_src_sel_i,
    input wire logic [`FSP_INV_W-1:0] invert_i,
    input wire logic tx_ref_clock_in_i,
    input wire logic tx_line_side_clock_i,
    input wire logic rx_line_clock_in_i,
    input wire logic tx_serial_in_i,
    input wire logic rx_line_binary_data_i,
    input wire logic rx_liu_data_i,
    output logic tx_marker_o,
    output logic tx_clock_out_o,
    output logic rx_serial_out_o,
    output logic rx_clock_out_o,
    output logic rx_marker_o,
    output logic [FIFO_WIDTH-1:0] tx_payload_data_o,
    output logic tx_payload_valid_o,
    input wire logic tx_payload_ready_i,
    input wire logic tx_overrun_clr_i,
    output logic tx_overrun_o
);
    localparam int BW = $clog2(FIFO_WIDTH + 1);

    function automatic logic [`FSP_POS_W-1:0] blk_len(framer_mode_e m);
        return (m == MODE_E3) ? `FSP_E3_BLOCK_BITS : `FSP_DS3_BLOCK_BITS;
    endfunction : blk_len

    function automatic logic [`FSP_POS_W-1:0] frm_len(framer_mode_e m);
        return (m == MODE_E3) ? `FSP_E3_FRAME_BITS : `FSP_DS3_FRAME_BITS;
    endfunction : frm_len

    function automatic logic is_pay(logic [`FSP_POS_W-1:0] b, framer_mode_e m);
        return (m == MODE_E3) ? (b >= `FSP_E3_OH_BITS) : (b >= `FSP_DS3_OH_BITS);
    endfunction : is_pay

    function automatic logic [`FSP_POS_W-1:0] step(logic [`FSP_POS_W-1:0] v,
                                                    logic [`FSP_POS_W-1:0] len);
        return (v == len - 1'b1) ? '0 : v + 1'b1;
    endfunction : step

    // Pin synchronisers, two stages each
    logic [`FSP_SYN_W-1:0] syn_in;
    logic [`FSP_SYN_W-1:0] syn1_r;
    logic [`FSP_SYN_W-1:0] syn2_r;

    assign syn_in[`FSP_SYN_TXREF] = tx_ref_clock_in_i;
    assign syn_in[`FSP_SYN_TXLCLK] = tx_line_side_clock_i;
    assign syn_in[`FSP_SYN_RXLCLK] = rx_line_clock_in_i;
    assign syn_in[`FSP_SYN_TXSER] = tx_serial_in_i;
    assign syn_in[`FSP_SYN_RXDAT] = rx_line_binary_data_i;
    assign syn_in[`FSP_SYN_RXLIU] = rx_liu_data_i;

    generate
        for (genvar i = 0; i < `FSP_SYN_W; i++)
        begin : g_sync
            always_ff @(posedge clk_sys_i or posedge rst_i)
            begin
                if (rst_i)
                begin
                    syn1_r[i] <= 1'b0;
                    syn2_r[i] <= 1'b0;
                end
                else
                begin
                    syn1_r[i] <= syn_in[i];
                    syn2_r[i] <= syn1_r[i];
                end
            end
        end
    endgenerate

    // Edges are ignored until the synchronisers and delayed copies hold real pin levels
    logic [3:0] arm_r;
    logic armed;
    assign armed = arm_r[3];

    always_ff @(posedge clk_sys_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            arm_r <= 4'h0;
        end
        else
        begin
            arm_r <= {arm_r[2:0], 1'b1};
        end
    end

    logic framed;
    assign framed = (framer_mode_i != MODE_UNFRAMED);

    // Internal framer clocks with pin inversion removed
    logic tx_fclk;
    logic rx_fclk;
    assign tx_fclk = syn2_r[`FSP_SYN_TXREF] ^ invert_i[`FSP_INV_TXREF];
    assign rx_fclk = syn2_r[`FSP_SYN_RXLCLK] ^ invert_i[`FSP_INV_RXLCLK];

    // Reference level and its inversion bit; active edge is pin rise, or fall if inverted
    logic tx_ref_lvl;
    logic tx_ref_inv;
    logic tx_ref_d_r;
    logic tx_edge;

    always_comb
    begin
        unique case (tx_ref_sel_i)
            TXREF_TX_CLOCK_IN:
            begin
                tx_ref_lvl = syn2_r[`FSP_SYN_TXREF];
                tx_ref_inv = invert_i[`FSP_INV_TXREF];
            end
            TXREF_TX_LINE_CLOCK:
            begin
                tx_ref_lvl = syn2_r[`FSP_SYN_TXLCLK];
                tx_ref_inv = invert_i[`FSP_INV_TXLCLK];
            end
            TXREF_TX_CLOCK_OUT:
            begin
                tx_ref_lvl = tx_clock_out_o;
                tx_ref_inv = invert_i[`FSP_INV_TXCLKO];
            end
            TXREF_RX_CLOCK_OUT:
            begin
                tx_ref_lvl = rx_clock_out_o;
                tx_ref_inv = invert_i[`FSP_INV_RXCLKO];
            end
            TXREF_RX_LINE_CLOCK:
            begin
                tx_ref_lvl = syn2_r[`FSP_SYN_RXLCLK];
                tx_ref_inv = invert_i[`FSP_INV_RXLCLK];
            end
            default:
            begin
                tx_ref_lvl = syn2_r[`FSP_SYN_TXREF];
                tx_ref_inv = invert_i[`FSP_INV_TXREF];
            end
        endcase
    end

    assign tx_edge = armed && (tx_ref_lvl != tx_ref_d_r)
                     && (tx_ref_lvl == ~tx_ref_inv);

    // Tx lead position: three bits ahead of the bit being sampled
    logic [`FSP_POS_W-1:0] tx_qblk_r;
    logic [`FSP_POS_W-1:0] tx_qfrm_r;
    logic [`FSP_POS_W-1:0] tx_qblk_nxt;
    logic [2:0] tx_pay_pipe_r;
    logic tx_mark_r;
    logic tx_pay_now;

    assign tx_qblk_nxt = step(tx_qblk_r, blk_len(framer_mode_i));
    assign tx_pay_now = tx_pay_pipe_r[2];

    always_ff @(posedge clk_sys_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            tx_ref_d_r <= 1'b0;
        end
        else
        begin
            tx_ref_d_r <= tx_ref_lvl;
        end
    end

    always_ff @(posedge clk_sys_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            tx_qblk_r <= `FSP_POS_W'(`FSP_MARKER_LEAD);
            tx_qfrm_r <= `FSP_POS_W'(`FSP_MARKER_LEAD);
            tx_pay_pipe_r <= 3'h0;
        end
        else if (tx_edge)
        begin
            tx_qblk_r <= tx_qblk_nxt;
            tx_qfrm_r <= step(tx_qfrm_r, frm_len(framer_mode_i));
            tx_pay_pipe_r <= {tx_pay_pipe_r[1:0], is_pay(tx_qblk_r, framer_mode_i)};
        end
    end

    // Marker looks at the lead position, so it runs three edges early
    always_ff @(posedge clk_sys_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            tx_mark_r <= 1'b0;
        end
        else if (!framed)
        begin
            tx_mark_r <= 1'b0;
        end
        else if (tx_edge)
        begin
            if (tx_marker_sel_i)
            begin
                // Window drops as the lead reaches the run's last payload bit
                tx_mark_r <= is_pay(tx_qblk_r, framer_mode_i)
                             && is_pay(tx_qblk_nxt, framer_mode_i);
            end
            else
            begin
                tx_mark_r <= (tx_qfrm_r == '0);
            end
        end
    end

    assign tx_marker_o = tx_mark_r ^ invert_i[`FSP_INV_TXMRK];

    // Tx clock output, continuous or gapped by the current payload bit
    logic tx_clkout_r;

    always_ff @(posedge clk_sys_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            tx_clkout_r <= 1'b0;
        end
        else if (tx_clk_sel_i && framed)
        begin
            tx_clkout_r <= (tx_fclk && tx_pay_now) ^ invert_i[`FSP_INV_TXCLKO];
        end
        else
        begin
            tx_clkout_r <= tx_fclk ^ invert_i[`FSP_INV_TXCLKO];
        end
    end

    assign tx_clock_out_o = tx_clkout_r;

    // Payload from the tx serial input packed into words, LSB first
    fsp_fifo_if #(.WIDTH(FIFO_WIDTH)) fifo_bus ();

    logic [FIFO_WIDTH-1:0] tx_shift_r;
    logic [BW-1:0] tx_bits_r;
    logic tx_push_r;
    logic [FIFO_WIDTH-1:0] tx_word_r;
    logic tx_bit;

    assign tx_bit = syn2_r[`FSP_SYN_TXSER] ^ invert_i[`FSP_INV_TXSER];

    // Only payload positions are taken, relying on the far side's alignment
    always_ff @(posedge clk_sys_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            tx_shift_r <= '0;
            tx_bits_r <= '0;
            tx_push_r <= 1'b0;
            tx_word_r <= '0;
        end
        else
        begin
            if (tx_push_r && fifo_bus.wr_ready)
            begin
                tx_push_r <= 1'b0;
            end
            if (framed && tx_edge && tx_pay_now)
            begin
                if (tx_bits_r == BW'(FIFO_WIDTH - 1))
                begin
                    tx_word_r <= {tx_bit, tx_shift_r[FIFO_WIDTH-1:1]};
                    tx_push_r <= 1'b1;
                    tx_bits_r <= '0;
                end
                else
                begin
                    tx_bits_r <= tx_bits_r + 1'b1;
                end
                tx_shift_r <= {tx_bit, tx_shift_r[FIFO_WIDTH-1:1]};
            end
        end
    end

    // Serial input cannot pause, so a word still waiting on a full FIFO when the next word completes is lost and flagged
    always_ff @(posedge clk_sys_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            tx_overrun_o <= 1'b0;
        end
        else if (tx_push_r && !fifo_bus.wr_ready && framed && tx_edge && tx_pay_now
                 && tx_bits_r == BW'(FIFO_WIDTH - 1))
        begin
            tx_overrun_o <= 1'b1;
        end
        else if (tx_overrun_clr_i)
        begin
            tx_overrun_o <= 1'b0;
        end
    end

    assign fifo_bus.wr_valid = tx_push_r;
    assign fifo_bus.wr_data = tx_word_r;
    assign fifo_bus.rd_ready = tx_payload_ready_i;
    assign tx_payload_valid_o = fifo_bus.rd_valid;
    assign tx_payload_data_o = fifo_bus.rd_data;

    fsp_fifo #(
        .WIDTH(FIFO_WIDTH),
        .DEPTH(FIFO_DEPTH)
    ) u_fifo (
        .clk_sys_i(clk_sys_i),
        .rst_i(rst_i),
        .bus(fifo_bus.store)
    );

    // Rx frame position advances on each internal framer clock rise
    logic rx_fclk_d_r;
    logic [`FSP_POS_W-1:0] rx_blk_r;
    logic [`FSP_POS_W-1:0] rx_frm_r;
    logic rx_pay;

    assign rx_pay = framed && is_pay(rx_blk_r, framer_mode_i);

    always_ff @(posedge clk_sys_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            rx_fclk_d_r <= 1'b0;
            rx_blk_r <= '0;
            rx_frm_r <= '0;
        end
        else
        begin
            rx_fclk_d_r <= rx_fclk;
            if (armed && rx_fclk && !rx_fclk_d_r)
            begin
                rx_blk_r <= step(rx_blk_r, blk_len(framer_mode_i));
                rx_frm_r <= step(rx_frm_r, frm_len(framer_mode_i));
            end
        end
    end

    // Rx clocks follow the line clock, hence its DS3 or E3 rate
    logic rx_cont_r;
    logic rx_gap_r;

    always_ff @(posedge clk_sys_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            rx_cont_r <= 1'b0;
            rx_gap_r <= 1'b0;
        end
        else
        begin
            rx_cont_r <= rx_fclk ^ invert_i[`FSP_INV_RXCLKO];
            rx_gap_r <= (rx_fclk && rx_pay) ^ invert_i[`FSP_INV_RXCLKO];
        end
    end

    assign rx_clock_out_o = (rx_clk_sel_i && framed) ? rx_gap_r : rx_cont_r;

    logic rx_ref_lvl;
    logic rx_ref_inv;
    logic rx_ref_d_r;
    logic rx_edge;

    always_comb
    begin
        unique case (rx_ref_sel_i)
            RXREF_RX_CLOCK_OUT:
            begin
                rx_ref_lvl = rx_cont_r;
                rx_ref_inv = invert_i[`FSP_INV_RXCLKO];
            end
            RXREF_RX_GAPPED:
            begin
                rx_ref_lvl = rx_gap_r;
                rx_ref_inv = invert_i[`FSP_INV_RXCLKO];
            end
            RXREF_RX_LINE_CLOCK:
            begin
                rx_ref_lvl = syn2_r[`FSP_SYN_RXLCLK];
                rx_ref_inv = invert_i[`FSP_INV_RXLCLK];
            end
            default:
            begin
                rx_ref_lvl = rx_cont_r;
                rx_ref_inv = invert_i[`FSP_INV_RXCLKO];
            end
        endcase
    end

    assign rx_edge = armed && (rx_ref_lvl != rx_ref_d_r)
                     && (rx_ref_lvl == ~rx_ref_inv);

    logic rx_ser_r;
    logic rx_mark_r;

    always_ff @(posedge clk_sys_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            rx_ref_d_r <= 1'b0;
            rx_ser_r <= 1'b0;
            rx_mark_r <= 1'b0;
        end
        else
        begin
            rx_ref_d_r <= rx_ref_lvl;
            if (!framed)
            begin
                rx_mark_r <= 1'b0;
            end
            if (rx_edge)
            begin
                rx_ser_r <= rx_src_sel_i ? syn2_r[`FSP_SYN_RXDAT]
                                         : syn2_r[`FSP_SYN_RXLIU];
                if (framed)
                begin
                    if (rx_marker_sel_i)
                    begin
                        rx_mark_r <= rx_pay;
                    end
                    else
                    begin
                        rx_mark_r <= (rx_frm_r == '0);
                    end
                end
            end
        end
    end

    assign rx_serial_out_o = rx_ser_r ^ invert_i[`FSP_INV_RXSER];
    assign rx_marker_o = rx_mark_r ^ invert_i[`FSP_INV_RXMRK];
endmodule : framer_sys_port

// file: tb/framer_sys_port_chk.sv
// Port-level assertions of the framer system-side port
`timescale 1ns/1ns
`include "fsp_cfg.svh"
module framer_sys_port_chk
    import fsp_pkg::*;
(
    input wire logic clk_sys_i,
    input wire logic rst_i,
    input wire framer_mode_e framer_mode_i,
    input wire logic tx_marker_sel_i,
    input wire logic rx_marker_sel_i,
    input wire logic rx_clk_sel_i,
    input wire logic [`FSP_INV_W-1:0] invert_i,
    input wire logic tx_marker_o,
    input wire logic rx_serial_out_o,
    input wire logic rx_clock_out_o,
    input wire logic rx_marker_o,
    input wire logic tx_payload_valid_o,
    input wire logic tx_overrun_clr_i,
    input wire logic tx_overrun_o
);
    logic tx_mk;
    logic rx_mk;
    logic unframed;
    assign tx_mk = tx_marker_o ^ invert_i[`FSP_INV_TXMRK];
    assign rx_mk = rx_marker_o ^ invert_i[`FSP_INV_RXMRK];
    assign unframed = framer_mode_i == MODE_UNFRAMED;

    // Clock outputs may step twice while the synchronisers fill after reset
    logic [2:0] settle_r;
    always_ff @(posedge clk_sys_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            settle_r <= 3'h0;
        end
        else if (settle_r != 3'h7)
        begin
            settle_r <= settle_r + 3'h1;
        end
    end

    default clocking @(posedge clk_sys_i);
    endclocking
    default disable iff (rst_i);

    AST_TX_REFUSED: assert property (unframed |-> !tx_mk)
        else $error("tx marker active while unframed");
    AST_RX_REFUSED: assert property (unframed |-> !rx_mk)
        else $error("rx marker active while unframed");
    // Reference period is eight system clocks, so a change must stand
    AST_TX_STANDS: assert property ($changed(tx_marker_o) |=> $stable(tx_marker_o)[*6])
        else $error("tx marker changed within a reference period");
    AST_TX_PULSE: assert property (!tx_marker_sel_i && $rose(tx_mk) |=> tx_mk[*6] ##[1:3] !tx_mk)
        else $error("tx frame pulse not one reference period");
    AST_RX_PULSE: assert property (!rx_marker_sel_i && $rose(rx_mk) |=> rx_mk[*6] ##[1:3] !rx_mk)
        else $error("rx frame pulse not one reference period");
    AST_RX_SER_STANDS: assert property ($changed(rx_serial_out_o) |=> $stable(rx_serial_out_o)[*6])
        else $error("rx data changed within a reference period");
    AST_RX_CLK_HALF: assert property (settle_r == 3'h7 && !rx_clk_sel_i && $changed(rx_clock_out_o)
        |=> $stable(rx_clock_out_o)[*2])
        else $error("rx clock half period too short");
    AST_RX_CLK_RUNS: assert property (!rx_clk_sel_i && !unframed |-> ##[1:10] $changed(rx_clock_out_o))
        else $error("rx clock stopped");
    // Gapping exists only in framed modes; unframed the pin keeps the continuous clock
    AST_GAPPED_OFF: assert property (unframed && rx_clk_sel_i |-> ##[1:10] $changed(rx_clock_out_o))
        else $error("rx clock stopped while unframed");
    AST_OVR_STICKY: assert property (tx_overrun_o && !tx_overrun_clr_i |=> tx_overrun_o)
        else $error("overrun flag lost without clear");
    AST_OVR_CAUSE: assert property ($rose(tx_overrun_o) |-> $past(tx_payload_valid_o))
        else $error("overrun with empty buffer");
endmodule : framer_sys_port_chk

bind framer_sys_port framer_sys_port_chk u_chk (
    .clk_sys_i(clk_sys_i), .rst_i(rst_i), .framer_mode_i(framer_mode_i),
    .tx_marker_sel_i(tx_marker_sel_i), .rx_marker_sel_i(rx_marker_sel_i),
    .rx_clk_sel_i(rx_clk_sel_i), .invert_i(invert_i), .tx_marker_o(tx_marker_o),
    .rx_serial_out_o(rx_serial_out_o), .rx_clock_out_o(rx_clock_out_o),
    .rx_marker_o(rx_marker_o), .tx_payload_valid_o(tx_payload_valid_o),
    .tx_overrun_clr_i(tx_overrun_clr_i), .tx_overrun_o(tx_overrun_o)
);

// file: tb/fsp_far_model.sv
// Far-side payload source driving the transmit serial input
`timescale 1ns/1ns
module fsp_far_model (
    input wire logic ref_clk_i,
    input wire logic rst_i,
    input wire logic window_i,
    output logic serial_o
);
    logic [2:0] seen_r;
    logic [10:0] bit_r;

    // Window sampled one edge late, when it has surely settled
    always_ff @(posedge ref_clk_i or posedge rst_i)
    begin
        if (rst_i)
            seen_r <= 3'h0;
        else
            seen_r <= {seen_r[1:0], window_i};
    end

    // Payload spans the window shifted by three, plus one bit past its fall
    always_ff @(negedge ref_clk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            serial_o <= 1'h1;
            bit_r <= 11'h000;
        end
        else if (seen_r[1] | seen_r[2])
        begin
            serial_o <= bit_r[3 + bit_r[2:0]];
            bit_r <= bit_r + 11'h001;
        end
        else
            serial_o <= 1'h1;
    end
endmodule : fsp_far_model

// file: tb/testbench.sv
// Self-checking bench of the framer system-side port
`timescale 1ns/1ns
module testbench
    import fsp_pkg::*;
;
    typedef struct {
        framer_mode_e mode;
        tx_ref_sel_e tsel;
        rx_ref_sel_e rsel;
        logic tmk, rmk, rclk, src;
        logic [8:0] inv;
        int th, tl, rh, rl;
    } row_s;
    // High and low spans in reference periods; DS3 frame start is too long to run
    row_s rows [5] = '{
        '{MODE_E3, TXREF_TX_CLOCK_IN, RXREF_RX_CLOCK_OUT, 0, 0, 0, 0, 9'h000, 1, 1535, 1, 1535},
        '{MODE_E3, TXREF_TX_LINE_CLOCK, RXREF_RX_LINE_CLOCK, 1, 1, 0, 1, 9'h000, 1523, 13, 1524, 12},
        '{MODE_DS3, TXREF_TX_CLOCK_OUT, RXREF_RX_CLOCK_OUT, 1, 1, 1, 0, 9'h150, 83, 2, 84, 1},
        '{MODE_DS3, TXREF_RX_LINE_CLOCK, RXREF_RX_LINE_CLOCK, 1, 1, 0, 1, 9'h007, 83, 2, 84, 1},
        '{MODE_DS3, TXREF_RX_CLOCK_OUT, RXREF_RX_CLOCK_OUT, 1, 1, 0, 0, 9'h1F8, 83, 2, 84, 1}};
    row_s cfg;
    logic clk, rst, lclk, rdy, clr, far_ser;
    // Set before any process runs, so the toggler never inverts an unknown
    logic line_interface_unit = 1'h0;
    logic tx_mrk, tx_ck, rx_ser, rx_ck, rx_mrk, pv, ovr, s0, s1;
    logic [7:0] pd;
    int n_errors, comparisons, th, tl, rh, rl;

    framer_sys_port uut (
        .clk_sys_i(clk), .rst_i(rst), .framer_mode_i(cfg.mode), .tx_marker_sel_i(cfg.tmk),
        .tx_clk_sel_i(cfg.src), .tx_ref_sel_i(cfg.tsel), .rx_ref_sel_i(cfg.rsel),
        .rx_clk_sel_i(cfg.rclk), .rx_marker_sel_i(cfg.rmk), .rx_src_sel_i(cfg.src),
        .invert_i(cfg.inv), .tx_ref_clock_in_i(lclk), .tx_line_side_clock_i(lclk),
        .rx_line_clock_in_i(lclk), .tx_serial_in_i(far_ser ^ cfg.inv[3]),
        .rx_line_binary_data_i(1'h1), .rx_liu_data_i(line_interface_unit), .tx_marker_o(tx_mrk),
        .tx_clock_out_o(tx_ck), .rx_serial_out_o(rx_ser), .rx_clock_out_o(rx_ck),
        .rx_marker_o(rx_mrk), .tx_payload_data_o(pd), .tx_payload_valid_o(pv),
        .tx_payload_ready_i(rdy), .tx_overrun_clr_i(clr), .tx_overrun_o(ovr));
    fsp_far_model far (.ref_clk_i(lclk ^ cfg.inv[0]), .rst_i(rst),
        .window_i(tx_mrk ^ cfg.inv[4]), .serial_o(far_ser));

    initial
    begin
        clk = 1'h0;
        forever #4 clk = ~clk;
    end
    // Link edges sit 3 ns off the system grid
    initial
    begin
        lclk = 1'h0;
        #3;
        forever #32 lclk = ~lclk;
    end
    // Line data moves on the inactive edge so sampling never races it
    always @(negedge (lclk ^ cfg.inv[2])) line_interface_unit <= ~line_interface_unit;

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp)
        begin
            n_errors++;
            $display("Error at %0t: seen %0h expected %0h", $time, seen, exp);
        end
    endtask : check

    function automatic logic mk(input logic rx);
        return rx ? rx_mrk ^ cfg.inv[8] : tx_mrk ^ cfg.inv[4];
    endfunction : mk

    task automatic restart(input row_s r);
        @(negedge clk);
        rst = 1'h1;
        cfg = r;
        repeat (12) @(negedge clk);
        check(tx_mrk, r.inv[4]);
        check(rx_mrk, r.inv[8]);
        // Release just after a link rise so far model and port count the same edges
        @(posedge lclk);
        @(negedge clk);
        rst = 1'h0;
    endtask : restart

    // Spans counted in system clocks and rounded; the first high span may be cut, so skipped
    task automatic measure(input logic rx, output int hi, output int lo);
        int n;
        n = 0;
        hi = 0;
        lo = 0;
        while (mk(rx) !== 1'h1 && n < 40000)
        begin
            @(negedge clk);
            n++;
        end
        while (mk(rx) === 1'h1 && n < 80000)
        begin
            @(negedge clk);
            n++;
        end
        while (mk(rx) === 1'h0 && lo < 40000)
        begin
            @(negedge clk);
            lo++;
        end
        while (mk(rx) === 1'h1 && hi < 40000)
        begin
            @(negedge clk);
            hi++;
        end
        hi = (hi + 4) / 8;
        lo = (lo + 4) / 8;
    endtask : measure

    task automatic conclude();
        $display("Comparisons %0d, mismatches %0d", comparisons, n_errors);
        if (n_errors == 0 && comparisons > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask : conclude

    initial
    begin
        rst = 1'h1;
        cfg = rows[0];
        rdy = 1'h1;
        clr = 1'h0;
        n_errors = 0;
        comparisons = 0;
        foreach (rows[i])
        begin
            restart(rows[i]);
            fork
                measure(1'h0, th, tl);
                measure(1'h1, rh, rl);
            join
            check(th, rows[i].th);
            check(tl, rows[i].tl);
            check(rh, rows[i].rh);
            check(rl, rows[i].rl);
            s0 = rx_ser;
            repeat (8) @(negedge clk);
            check(s0 ^ rx_ser, !rows[i].src);
            $display("Row %0d done", i);
        end
        restart(row_s'{MODE_UNFRAMED, TXREF_TX_CLOCK_IN, RXREF_RX_CLOCK_OUT, 0, 0, 1, 0,
            9'h080, 0, 0, 0, 0});
        repeat (2000) @(negedge clk);
        check(tx_mrk, 1'h0);
        s0 = rx_ck;
        s1 = tx_ck;
        repeat (4) @(negedge clk);
        check(s0 ^ rx_ck, 1'h1);
        check(s1 ^ tx_ck, 1'h1);
        check(pv, 1'h0);
        $display("Unframed test done");
        rdy = 1'h0;
        restart(row_s'{MODE_DS3, TXREF_TX_CLOCK_IN, RXREF_RX_LINE_CLOCK, 1, 1, 0, 1,
            9'h1FF, 0, 0, 0, 0});
        repeat (3200) @(negedge clk);
        check(ovr, 1'h1);
        check(pv, 1'h1);
        for (int i = 0; i < 32; i++)
        begin
            check(pd, i);
            rdy = 1'h1;
            @(negedge clk);
            rdy = 1'h0;
            @(negedge clk);
        end
        clr = 1'h1;
        @(negedge clk);
        clr = 1'h0;
        @(negedge clk);
        check(ovr, 1'h0);
        rdy = 1'h1;
        $display("Overflow test done");
        conclude();
    end

    // About 60k cycles expected; the limit leaves margin
    initial
    begin
        #800000;
        n_errors++;
        $display("Watchdog expired");
        conclude();
    end
endmodule : testbench
